// *** supervisor_pkg.sv ***
// shared constants, types and state decode for the supervisor mode control
// Notes on behaviour
// - An enabled low-side supervisor with its fast performance bit clear selects slow wake-up, about 150 us.
// - With high-side automatic control set, the high-side monitor is off throughout deep sleep two to four.
// - With overvoltage protect enabled, a main supply overvoltage trip of the active high-side monitor raises a power-on reset.
// - A low-side supervisor or monitor enabled in normal performance selects slow wake-up.
// - A high-side supervisor enabled in normal mode without the low-power select turns off in deep sleep two to four.
// - High-side modules under manual control with the low-power select keep their active state in every sleep mode.
// - A low-side configuration change in full performance holds the settle flag about 2 us.
// - A low-side configuration change in normal mode holds the settle flag about 150 us.
package supervisor_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SETTLE_FULL_NS = 2000;
    localparam int SETTLE_NORMAL_NS = 150000;
    localparam int WAKE_SLOW_NS = 150000;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] SETTLE_FULL_CYC =
        CNT_W'((SETTLE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SETTLE_NORMAL_CYC =
        CNT_W'((SETTLE_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WAKE_SLOW_CYC =
        CNT_W'((WAKE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_HIGH_CTL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_LOW_CTL = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // control register fields, both sides share the layout
    localparam int CTL_W = 8;
    localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;
    localparam int BIT_SVS_EN = 0;
    localparam int BIT_SVS_LP = 1;
    localparam int BIT_SVS_FP = 2;
    localparam int BIT_SVM_EN = 3;
    localparam int BIT_SVM_FP = 4;
    localparam int BIT_AUTO = 5;
    localparam int BIT_OVP_EN = 6;
    localparam int BIT_EVT_POR = 7;

    // status register fields
    localparam int ST_W = 4;
    localparam int ST_LS_DLY = 0;
    localparam int ST_HS_DLY = 1;
    localparam int ST_LS_EVT = 2;
    localparam int ST_HS_EVT = 3;

    // trip inputs and timers
    localparam int N_TRIP = 5;
    localparam int TRIP_LS_SVS = 0;
    localparam int TRIP_LS_SVM = 1;
    localparam int TRIP_HS_SVS = 2;
    localparam int TRIP_HS_SVM = 3;
    localparam int TRIP_HS_OVER = 4;
    localparam int N_TMR = 3;
    localparam int TMR_LS = 0;
    localparam int TMR_HS = 1;
    localparam int TMR_WAKE = 2;

    typedef enum logic [1:0] {SUP_OFF, SUP_NORMAL, SUP_FULL} sup_state_e;
    typedef enum logic [1:0] {MODE_ACTIVE, MODE_LIGHT, MODE_DEEP} pwr_mode_e;

    // monitors have no low-power select and pass lp_sel = 1
    function automatic sup_state_e sup_decode(input logic en,
        input logic lp_sel, input logic fp, input logic auto_c,
        input logic deep);
        sup_state_e act;
        act = !en ? SUP_OFF : (fp ? SUP_FULL : SUP_NORMAL);
        if (!deep || !en)
            return act;
        if (!lp_sel)
            return SUP_OFF;
        if (!auto_c)
            return act;
        return fp ? SUP_NORMAL : SUP_OFF;
    endfunction
endpackage

// *** delay_timer_if.sv ***
// carrier between the mode control and one delay timer
`timescale 1ns/100ps
`default_nettype none
interface delay_timer_if;
    import supervisor_pkg::*;
    logic ce;
    logic start;
    logic [CNT_W-1:0] load;
    logic busy;
    modport ctrl (output ce, output start, output load, input busy);
    modport tmr (input ce, input start, input load, output busy);
endinterface
`default_nettype wire

// *** delay_timer.sv ***
// down-counting delay timer with a registered busy flag
`timescale 1ns/100ps
`default_nettype none
module delay_timer
    import supervisor_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control side
    delay_timer_if.tmr t
);
    logic [CNT_W-1:0] cnt_q;
    logic busy_q;

    // restart on start, so a rewrite extends the delay
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (t.ce) begin
            if (t.start) begin
                cnt_q <= t.load;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
        end else if (t.ce) begin
            if (t.start) begin
                busy_q <= (t.load != '0);
            end else if (cnt_q == CNT_W'(1)) begin
                busy_q <= 1'b0;
            end
        end
    end

    assign t.busy = busy_q;
endmodule
`default_nettype wire

// *** supply_supervisor_mode_control.sv ***
// supervisor and monitor mode control with AXI4-Lite register access
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module supply_supervisor_mode_control
    import supervisor_pkg::*;
(
    // clock, reset, enable
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CE,
    // AXI4-Lite write
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // AXI4-Lite read
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    output logic RVALID,
    input wire logic RREADY,
    output logic [DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    // power mode from the core, same clock
    input wire logic [1:0] PWR_MODE,
    // analog comparator trips, asynchronous
    input wire logic LS_SVS_TRIP,
    input wire logic LS_SVM_TRIP,
    input wire logic HS_SVS_TRIP,
    input wire logic HS_SVM_TRIP,
    input wire logic HS_OVER_TRIP,
    // module states
    output logic [1:0] LS_SVS_STATE,
    output logic [1:0] LS_SVM_STATE,
    output logic [1:0] HS_SVS_STATE,
    output logic [1:0] HS_SVM_STATE,
    // wake-up and settle
    output logic WAKE_SLOW,
    output logic WAKE_BUSY,
    output logic LS_DLY_FLAG,
    output logic HS_DLY_FLAG,
    // event outputs, one-cycle pulses
    output logic POR_REQ,
    output logic INT_REQ
);
    logic [CTL_W-1:0] high_side_supervisor_control_q;
    logic [CTL_W-1:0] low_side_supervisor_control_q;
    logic ls_evt_q, hs_evt_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_have_q, w_have_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [CTL_W-1:0] wdata_q;
    logic wstrb0_q;
    logic [1:0] bresp_q, rresp_q;
    logic [DATA_W-1:0] rdata_q;
    logic [N_TRIP-1:0] sync1_q, sync2_q, sync3_q;
    sup_state_e ls_svs_q, ls_svm_q, hs_svs_q, hs_svm_q;
    logic wake_slow_q, deep_prev_q, por_q, int_q;

    logic wr_fire, wr_high, wr_low, wr_stat, wr_ok;
    logic deep, rd_ok, ls_evt, hs_svs_evt, hs_svm_evt, ovp_evt;
    logic [DATA_W-1:0] rd_word;
    logic [N_TRIP-1:0] trip_edge;
    logic [CTL_W-1:0] hc, lc;
    logic [ST_W-1:0] status;

    delay_timer_if tmr_if[N_TMR] ();

    generate
        for (genvar i = 0; i < N_TMR; i++) begin : g_tmr
            assign tmr_if[i].ce = CE;
            delay_timer u_tmr (
                .clk(CLK),
                .arst_n(ARST_N),
                .t(tmr_if[i])
            );
        end
    endgenerate

    assign hc = high_side_supervisor_control_q;
    assign lc = low_side_supervisor_control_q;
    // an illegal mode code is treated as the deepest sleep
    assign deep = (PWR_MODE != MODE_ACTIVE) && (PWR_MODE != MODE_LIGHT);

    // write path: address and data taken in either order
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign wr_high = wr_fire && wstrb0_q
        && (wr_addr_q[ADDR_W-1:2] == ADDR_HIGH_CTL[ADDR_W-1:2]);
    assign wr_low = wr_fire && wstrb0_q
        && (wr_addr_q[ADDR_W-1:2] == ADDR_LOW_CTL[ADDR_W-1:2]);
    assign wr_stat = wr_fire && wstrb0_q
        && (wr_addr_q[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2]);
    assign wr_ok = (wr_addr_q[ADDR_W-1:2] == ADDR_HIGH_CTL[ADDR_W-1:2])
        || (wr_addr_q[ADDR_W-1:2] == ADDR_LOW_CTL[ADDR_W-1:2])
        || (wr_addr_q[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2]);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            awready_q <= 1'b1;
            aw_have_q <= 1'b0;
            wr_addr_q <= '0;
        end else if (CE) begin
            if (AWVALID && awready_q) begin
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
                wr_addr_q <= AWADDR;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (bvalid_q && BREADY) begin
                awready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wready_q <= 1'b1;
            w_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end else if (CE) begin
            if (WVALID && wready_q) begin
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q <= WDATA[CTL_W-1:0];
                wstrb0_q <= WSTRB[0];
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
            if (bvalid_q && BREADY) begin
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (CE) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // settle delay restarts on every write to a control register that strobes its low byte
    assign tmr_if[TMR_LS].start = CE && wr_low;
    assign tmr_if[TMR_LS].load = wdata_q[BIT_SVS_FP]
        ? SETTLE_FULL_CYC : SETTLE_NORMAL_CYC;
    assign tmr_if[TMR_HS].start = CE && wr_high;
    assign tmr_if[TMR_HS].load = wdata_q[BIT_SVS_FP]
        ? SETTLE_FULL_CYC : SETTLE_NORMAL_CYC;
    assign tmr_if[TMR_WAKE].start = CE && deep_prev_q && !deep
        && wake_slow_q;
    assign tmr_if[TMR_WAKE].load = WAKE_SLOW_CYC;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            high_side_supervisor_control_q <= CTL_RESET;
            low_side_supervisor_control_q <= CTL_RESET;
        end else if (CE) begin
            if (wr_high) begin
                high_side_supervisor_control_q <= wdata_q;
            end
            if (wr_low) begin
                low_side_supervisor_control_q <= wdata_q;
            end
        end
    end

    // read path
    assign status = {hs_evt_q, ls_evt_q, tmr_if[TMR_HS].busy,
        tmr_if[TMR_LS].busy};

    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        if (ARADDR[ADDR_W-1:2] == ADDR_HIGH_CTL[ADDR_W-1:2]) begin
            rd_word = DATA_W'(hc);
        end else if (ARADDR[ADDR_W-1:2] == ADDR_LOW_CTL[ADDR_W-1:2]) begin
            rd_word = DATA_W'(lc);
        end else if (ARADDR[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2]) begin
            rd_word = DATA_W'(status);
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (CE) begin
            if (ARVALID && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && RREADY) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // trip synchronisers, third stage only for edge detection
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else if (CE) begin
            sync1_q <= {HS_OVER_TRIP, HS_SVM_TRIP, HS_SVS_TRIP,
                LS_SVM_TRIP, LS_SVS_TRIP};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // trips other than the overvoltage trip are ignored while the side is still settling
    assign trip_edge = sync2_q & ~sync3_q;
    assign ls_evt = !tmr_if[TMR_LS].busy
        && ((trip_edge[TRIP_LS_SVS] && ls_svs_q != SUP_OFF)
        || (trip_edge[TRIP_LS_SVM] && ls_svm_q != SUP_OFF));
    assign hs_svs_evt = !tmr_if[TMR_HS].busy
        && trip_edge[TRIP_HS_SVS] && hs_svs_q != SUP_OFF;
    assign hs_svm_evt = !tmr_if[TMR_HS].busy && !hc[BIT_OVP_EN]
        && trip_edge[TRIP_HS_SVM] && hs_svm_q != SUP_OFF;
    assign ovp_evt = hc[BIT_OVP_EN] && trip_edge[TRIP_HS_OVER]
        && hs_svm_q != SUP_OFF;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            por_q <= 1'b0;
            int_q <= 1'b0;
        end else if (CE) begin
            por_q <= (ls_evt && lc[BIT_EVT_POR]) || hs_svs_evt
                || ovp_evt;
            int_q <= (ls_evt && !lc[BIT_EVT_POR]) || hs_svm_evt;
        end
    end

    // sticky event flags, a new event beats a write-one clear
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ls_evt_q <= 1'b0;
            hs_evt_q <= 1'b0;
        end else if (CE) begin
            ls_evt_q <= ls_evt || (ls_evt_q && !(wr_stat
                && wdata_q[ST_LS_EVT]));
            hs_evt_q <= hs_svs_evt || hs_svm_evt || ovp_evt
                || (hs_evt_q && !(wr_stat && wdata_q[ST_HS_EVT]));
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ls_svs_q <= SUP_OFF;
            ls_svm_q <= SUP_OFF;
            hs_svs_q <= SUP_OFF;
            hs_svm_q <= SUP_OFF;
        end else if (CE) begin
            ls_svs_q <= sup_decode(lc[BIT_SVS_EN], lc[BIT_SVS_LP],
                lc[BIT_SVS_FP], lc[BIT_AUTO], deep);
            ls_svm_q <= sup_decode(lc[BIT_SVM_EN], 1'b1,
                lc[BIT_SVM_FP], lc[BIT_AUTO], deep);
            hs_svs_q <= sup_decode(hc[BIT_SVS_EN], hc[BIT_SVS_LP],
                hc[BIT_SVS_FP], hc[BIT_AUTO], deep);
            // automatic control parks the high monitor in deep sleep
            hs_svm_q <= (deep && hc[BIT_AUTO]) ? SUP_OFF
                : sup_decode(hc[BIT_SVM_EN], 1'b1, hc[BIT_SVM_FP],
                hc[BIT_AUTO], deep);
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wake_slow_q <= 1'b0;
            deep_prev_q <= 1'b0;
        end else if (CE) begin
            wake_slow_q <= (lc[BIT_SVS_EN] && !lc[BIT_SVS_FP])
                || (lc[BIT_SVM_EN] && !lc[BIT_SVM_FP]);
            deep_prev_q <= deep;
        end
    end

    assign AWREADY = awready_q;
    assign WREADY = wready_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID = rvalid_q;
    assign RDATA = rdata_q;
    assign RRESP = rresp_q;
    assign LS_SVS_STATE = ls_svs_q;
    assign LS_SVM_STATE = ls_svm_q;
    assign HS_SVS_STATE = hs_svs_q;
    assign HS_SVM_STATE = hs_svm_q;
    assign WAKE_SLOW = wake_slow_q;
    assign WAKE_BUSY = tmr_if[TMR_WAKE].busy;
    assign LS_DLY_FLAG = tmr_if[TMR_LS].busy;
    assign HS_DLY_FLAG = tmr_if[TMR_HS].busy;
    assign POR_REQ = por_q;
    assign INT_REQ = int_q;

    // helper: length of the low-side settle window
    logic [CNT_W-1:0] ls_len_q;
    logic ls_fast_q;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ls_len_q <= '0;
            ls_fast_q <= 1'b0;
        end else if (CE) begin
            if (tmr_if[TMR_LS].start) begin
                ls_len_q <= '0;
                ls_fast_q <= wdata_q[BIT_SVS_FP];
            end else if (LS_DLY_FLAG) begin
                ls_len_q <= ls_len_q + CNT_W'(1);
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    chk_write_sets_flag: assert property (
        CE && wr_low |=> LS_DLY_FLAG)
        else $error("settle flag not raised by low-side write");
    chk_ls_full_settle: assert property (
        $fell(LS_DLY_FLAG) && ls_fast_q |-> ls_len_q == SETTLE_FULL_CYC)
        else $error("full performance settle length wrong");
    chk_ls_normal_settle: assert property (
        $fell(LS_DLY_FLAG) && !ls_fast_q
        |-> ls_len_q == SETTLE_NORMAL_CYC)
        else $error("normal mode settle length wrong");
    chk_wake_slow_fp: assert property (
        CE && lc[BIT_SVS_EN] && !lc[BIT_SVS_FP] |=> WAKE_SLOW)
        else $error("slow wake-up not selected");
    chk_slow_on_normal: assert property (
        CE && lc[BIT_SVM_EN] && !lc[BIT_SVM_FP] |=> WAKE_SLOW)
        else $error("normal monitor did not force slow wake-up");
    chk_hs_mon_auto: assert property (
        CE && deep && hc[BIT_AUTO] |=> HS_SVM_STATE == SUP_OFF)
        else $error("high monitor active in deep sleep under auto");
    chk_ovp_por_raise: assert property (
        CE && ovp_evt && !ls_evt |=> POR_REQ && !INT_REQ)
        else $error("overvoltage trip gave no reset");
    chk_ls_evt_route: assert property (
        CE && ls_evt |=> ($past(lc[BIT_EVT_POR]) ? POR_REQ : INT_REQ))
        else $error("low-side event routed wrongly");
    chk_hs_off_deep: assert property (
        CE && deep && hc[BIT_SVS_EN] && !hc[BIT_SVS_LP]
        |=> HS_SVS_STATE == SUP_OFF)
        else $error("high supervisor stayed on in deep sleep");
    chk_hs_manual_on: assert property (
        CE && hc[BIT_SVS_EN] && hc[BIT_SVS_LP] && !hc[BIT_AUTO]
        |=> HS_SVS_STATE == ($past(hc[BIT_SVS_FP]) ? SUP_FULL : SUP_NORMAL))
        else $error("manual high supervisor did not keep state");
    chk_disabled_off: assert property (
        CE && !lc[BIT_SVS_EN] |=> LS_SVS_STATE == SUP_OFF)
        else $error("disabled low supervisor not off");

    cov_settle_done: cover property ($fell(LS_DLY_FLAG));
    cov_slow_wake: cover property ($rose(WAKE_BUSY));
    cov_por: cover property (POR_REQ);
    cov_int: cover property (INT_REQ);
endmodule
`default_nettype wire

// *** supply_supervisor_mode_control_bench.sv ***
// self-checking bench for the supervisor mode control
`timescale 1ns/100ps
`default_nettype none
module supply_supervisor_mode_control_bench;
    import supervisor_pkg::*;
    logic CLK = 0, ARST_N = 0, CE = 1;
    logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic [ADDR_W-1:0] AWADDR = '0, ARADDR = '0;
    logic [DATA_W-1:0] WDATA = '0;
    logic [3:0] WSTRB = 4'hF;
    logic [1:0] PWR_MODE = 2'h0;
    logic [N_TRIP-1:0] trip = '0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, WAKE_SLOW, WAKE_BUSY;
    logic LS_DLY_FLAG, HS_DLY_FLAG, POR_REQ, INT_REQ;
    logic [1:0] BRESP, RRESP, LS_SVS_STATE, LS_SVM_STATE;
    logic [1:0] HS_SVS_STATE, HS_SVM_STATE;
    logic [DATA_W-1:0] RDATA;
    logic [2:0] fl;
    logic [7:0] hi, lo;
    logic [1:0] m;
    int bad_count = 0, n_checks = 0;
    int run[3] = '{0, 0, 0}, len[3] = '{0, 0, 0};
    logic [1:0] bq[$], eq[$];
    logic [33:0] rq[$];

    supply_supervisor_mode_control u_dut (.CLK(CLK), .ARST_N(ARST_N),
        .CE(CE), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
        .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
        .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
        .PWR_MODE(PWR_MODE), .LS_SVS_TRIP(trip[TRIP_LS_SVS]),
        .LS_SVM_TRIP(trip[TRIP_LS_SVM]), .HS_SVS_TRIP(trip[TRIP_HS_SVS]),
        .HS_SVM_TRIP(trip[TRIP_HS_SVM]), .HS_OVER_TRIP(trip[TRIP_HS_OVER]),
        .LS_SVS_STATE(LS_SVS_STATE), .LS_SVM_STATE(LS_SVM_STATE),
        .HS_SVS_STATE(HS_SVS_STATE), .HS_SVM_STATE(HS_SVM_STATE),
        .WAKE_SLOW(WAKE_SLOW), .WAKE_BUSY(WAKE_BUSY),
        .LS_DLY_FLAG(LS_DLY_FLAG), .HS_DLY_FLAG(HS_DLY_FLAG),
        .POR_REQ(POR_REQ), .INT_REQ(INT_REQ));

    assign fl = {WAKE_BUSY, HS_DLY_FLAG, LS_DLY_FLAG};
    always #25 CLK = ~CLK;

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic hang();
        bad_count++;
        stop_test();
    endtask

    // own decode of the mode table, kept apart from the design's
    function automatic logic [1:0] dec(input logic en, lp, fp, au, dp);
        if (!en)
            return 2'h0;
        if (!dp || (lp && !au))
            return fp ? 2'h2 : 2'h1;
        if (!lp)
            return 2'h0;
        return fp ? 2'h1 : 2'h0;
    endfunction

    // scoreboard: every answer takes the oldest note
    always @(posedge CLK) begin
        if (BVALID === 1'b1 && BREADY === 1'b1)
            check(BRESP, bq.size() ? bq.pop_front() : 2'hX);
        if (RVALID === 1'b1 && RREADY === 1'b1)
            check({RRESP, RDATA}, rq.size() ? rq.pop_front() : 'X);
        if (POR_REQ === 1'b1 || INT_REQ === 1'b1)
            check({POR_REQ, INT_REQ}, eq.size() ? eq.pop_front() : 2'h0);
        for (int i = 0; i < 3; i++) begin
            if (fl[i] === 1'b1) begin
                run[i]++;
            end else if (run[i] != 0) begin
                len[i] = run[i];
                run[i] = 0;
            end
        end
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d,
        input logic [1:0] r);
        int k;
        logic aw, w;
        bq.push_back(r);
        @(posedge CLK);
        AWVALID <= 1'b1;
        AWADDR <= a;
        WVALID <= 1'b1;
        WDATA <= {24'h000000, d};
        BREADY <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        k = 0;
        do begin
            @(posedge CLK);
            k++;
            if (aw && AWREADY === 1'b1) begin
                aw = 1'b0;
                AWVALID <= 1'b0;
            end
            if (w && WREADY === 1'b1) begin
                w = 1'b0;
                WVALID <= 1'b0;
            end
        end while ((aw || w) && k < 1000);
        while (BVALID !== 1'b1 && k < 2000) begin
            @(posedge CLK);
            k++;
        end
        BREADY <= 1'b0;
        if (k >= 1000)
            hang();
    endtask

    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        int k;
        rq.push_back(e);
        @(posedge CLK);
        ARVALID <= 1'b1;
        ARADDR <= a;
        RREADY <= 1'b1;
        k = 0;
        do begin
            @(posedge CLK);
            k++;
        end while (ARREADY !== 1'b1 && k < 1000);
        ARVALID <= 1'b0;
        while (RVALID !== 1'b1 && k < 2000) begin
            @(posedge CLK);
            k++;
        end
        RREADY <= 1'b0;
        if (k >= 1000)
            hang();
    endtask

    // a flag must have dropped before its length is read
    task automatic wait_fl(input int i);
        int k;
        k = 0;
        while (fl[i] !== 1'b0 && k < 4000) begin
            @(posedge CLK);
            k++;
        end
        if (k >= 4000)
            hang();
        @(posedge CLK);
        #1;
    endtask

    task automatic pm(input logic [1:0] v, input int hold);
        @(posedge CLK);
        PWR_MODE <= v;
        repeat (hold) @(posedge CLK);
    endtask

    task automatic evt(input int i, input logic [1:0] e);
        if (e != 2'h0)
            eq.push_back(e);
        @(posedge CLK);
        trip[i] <= 1'b1;
        repeat (2) @(posedge CLK);
        trip[i] <= 1'b0;
        repeat (6) @(posedge CLK);
        check(eq.size(), 0);
    endtask

    initial begin
        void'($urandom(32'hDFE2D9CB));
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        rd(ADDR_HIGH_CTL, 34'h0);
        rd(ADDR_STATUS, 34'h0);
        rd(4'hC, {RESP_SLVERR, 32'h0});
        wr(4'hC, 8'hFF, RESP_SLVERR);
        for (int n = 0; n < 40; n++) begin
            hi = 8'($urandom);
            lo = 8'($urandom);
            m = 2'($urandom);
            wr(ADDR_HIGH_CTL, hi, RESP_OKAY);
            wr(ADDR_LOW_CTL, lo, RESP_OKAY);
            rd(ADDR_LOW_CTL, {RESP_OKAY, 24'h0, lo});
            // deep sleep only once both sides have settled
            if (m[1]) begin
                wait_fl(0);
                wait_fl(1);
            end
            pm(m, 2);
            check({WAKE_SLOW, HS_SVS_STATE, HS_SVM_STATE, LS_SVS_STATE,
                LS_SVM_STATE}, {(lo[0] & ~lo[2]) | (lo[3] & ~lo[4]),
                dec(hi[0], hi[1], hi[2], hi[5], m[1]),
                (m[1] & hi[5]) ? 2'h0 : dec(hi[3], 1'b1, hi[4], hi[5], m[1]),
                dec(lo[0], lo[1], lo[2], lo[5], m[1]),
                dec(lo[3], 1'b1, lo[4], lo[5], m[1])});
            pm(2'h0, 1);
        end
        // a window still open would merge with the next one
        wait_fl(0);
        wait_fl(1);
        wr(ADDR_LOW_CTL, 8'h04, RESP_OKAY);
        wait_fl(0);
        check(len[0], SETTLE_FULL_CYC);
        wr(ADDR_LOW_CTL, 8'h01, RESP_OKAY);
        wait_fl(0);
        check(len[0], SETTLE_NORMAL_CYC);
        wr(ADDR_HIGH_CTL, 8'h00, RESP_OKAY);
        wait_fl(1);
        check(len[1], SETTLE_NORMAL_CYC);
        pm(2'h2, 4);
        pm(2'h0, 2);
        wait_fl(2);
        check(len[2], WAKE_SLOW_CYC);
        wr(ADDR_LOW_CTL, 8'h05, RESP_OKAY);
        wait_fl(0);
        pm(2'h2, 4);
        pm(2'h0, 4);
        check({WAKE_SLOW, WAKE_BUSY}, 2'h0);
        wr(ADDR_LOW_CTL, 8'h85, RESP_OKAY);
        wait_fl(0);
        evt(TRIP_LS_SVS, 2'b10);
        wr(ADDR_LOW_CTL, 8'h0D, RESP_OKAY);
        wait_fl(0);
        evt(TRIP_LS_SVM, 2'b01);
        rd(ADDR_STATUS, {RESP_OKAY, 32'h4});
        wr(ADDR_STATUS, 8'h04, RESP_OKAY);
        rd(ADDR_STATUS, {RESP_OKAY, 32'h0});
        // a write without its low byte strobe changes nothing
        WSTRB <= 4'hE;
        wr(ADDR_LOW_CTL, 8'hFF, RESP_OKAY);
        WSTRB <= 4'hF;
        rd(ADDR_LOW_CTL, {RESP_OKAY, 32'h0D});
        wr(ADDR_HIGH_CTL, 8'h5C, RESP_OKAY);
        wait_fl(1);
        evt(TRIP_HS_OVER, 2'b10);
        evt(TRIP_HS_SVM, 2'b00);
        // trip inside the settle window is ignored
        wr(ADDR_HIGH_CTL, 8'h1D, RESP_OKAY);
        evt(TRIP_HS_SVS, 2'b00);
        wait_fl(1);
        evt(TRIP_HS_SVS, 2'b10);
        evt(TRIP_HS_SVM, 2'b01);
        rd(ADDR_STATUS, {RESP_OKAY, 32'h8});
        stop_test();
    end
endmodule
`default_nettype wire
